// ---- common/byte_if.sv ----
// Purpose: valid/ready byte stream between handler modules
// Assumes: single clock domain
// Notes: source drives valid and data, sink drives ready
`timescale 1ns/1ps
interface byte_if #(parameter int width = 8);
	logic             valid;
	logic             ready;
	logic [width-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface : byte_if

// ---- common/msg_pkg.sv ----
// Purpose: constants and types shared by the message handler and its helpers
// Assumes: 125 MHz mclk
// Notes: command codes and register resets are the device's own values
package msg_pkg;
	localparam logic [7:0] cmd_set_cfg0    = 8'h81;
	localparam logic [7:0] cmd_get_cfg0    = 8'h82;
	localparam logic [7:0] cmd_set_cfg1    = 8'h83;
	localparam logic [7:0] cmd_get_cfg1    = 8'h84;
	localparam logic [7:0] cmd_status0     = 8'h85;
	localparam logic [7:0] cmd_status1     = 8'h86;
	localparam logic [7:0] cmd_set_cfg2    = 8'h87;
	localparam logic [7:0] cmd_get_cfg2    = 8'h88;
	localparam int         resp_bit        = 7;
	localparam int         ack_bit         = 6;
	localparam int         cfg0_rsvd_bit   = 7;
	localparam int         cfg0_pu_bit     = 6;
	localparam int         cfg0_sleep_bit  = 5;
	localparam int         cfg0_neut_bit   = 4;
	localparam int         cfg0_uvlo_bit   = 3;
	localparam int         cfg0_short_bit  = 2;
	localparam int         restart_bit     = 0;
	localparam logic [7:0] cfg0_reset      = 8'h00;
	localparam logic [7:0] cfg1_reset      = 8'h40;
	localparam logic [7:0] cfg2_reset      = 8'h00;
	localparam logic [7:0] rsvd_mask_cfg2  = 8'h1f;
	localparam int         clk_mhz         = 125;
	localparam int         timeout_ms      = 5;
	localparam int         timeout_cycles  = timeout_ms * 1000 * clk_mhz;
	localparam int         fifo_depth      = 8;
	localparam int         byte_w          = 8;
	typedef enum logic [2:0] {st_idle, st_cmd, st_wait_data, st_reply, st_reply_data} hstate_t;
endpackage : msg_pkg

// ---- rtl/byte_fifo.sv ----
// Purpose: small synchronous fifo for outgoing bytes
// Assumes: depth is a power of two
// Notes: read data come from a register; out valid means that register holds a word
`timescale 1ns/1ps
module byte_fifo #(
	parameter int width = 8,
	parameter int depth = 8
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// streams
	byte_if.sink      wr,
	byte_if.source    rd
);
	localparam int aw = $clog2(depth);
	typedef struct packed {
		logic [aw:0]      wp;
		logic [aw:0]      rp;
		logic             ov;
		logic [width-1:0] od;
	} fstate_t;
	fstate_t          s_reg;
	fstate_t          s_next;
	logic [width-1:0] mem [depth];
	logic             empty;
	logic             full;
	logic             pop;

	assign empty    = (s_reg.wp == s_reg.rp);
	assign full     = (s_reg.wp[aw] != s_reg.rp[aw]) && (s_reg.wp[aw-1:0] == s_reg.rp[aw-1:0]);
	assign wr.ready = !full;
	assign rd.valid = s_reg.ov;
	assign rd.data  = s_reg.od;
	assign pop      = !empty && (!s_reg.ov || rd.ready);

	always_comb begin
		s_next = s_reg;
		if (wr.valid && !full)
			s_next.wp = s_reg.wp + 1'b1;
		if (rd.ready)
			s_next.ov = 1'b0;
		if (pop) begin
			s_next.od = mem[s_reg.rp[aw-1:0]];
			s_next.ov = 1'b1;
			s_next.rp = s_reg.rp + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (clk_en && wr.valid && !full)
			mem[s_reg.wp[aw-1:0]] <= wr.data;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			s_reg <= '0;
		else if (clk_en)
			s_reg <= s_next;
	end

	a_fifo_no_overrun: assert property (@(posedge mclk) disable iff (sys_rst)
		full && wr.valid |=> s_reg.wp == $past(s_reg.wp)) else $error("fifo accepts while full");
endmodule : byte_fifo

// ---- rtl/fault_flags.sv ----
// Purpose: sticky fault and restart flags with clear handling
// Assumes: fault inputs are levels synchronous to mclk
// Notes: a fault rising on a bit whose flag is clear raises a report request; clears keep bits whose fault persists
`timescale 1ns/1ps
module fault_flags #(
	parameter int width = 8
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	// faults and clears
	input  wire logic [width-1:0] fault_in,
	input  wire logic             set_extra,
	input  wire logic             clear,
	input  wire logic             clear_extra,
	// state
	output logic      [width-1:0] flags,
	output logic                  rise
);
	typedef struct packed {
		logic [width-1:0] f;
		logic [width-1:0] prev;
		logic             r;
	} ffstate_t;
	ffstate_t s_reg;
	ffstate_t s_next;

	assign flags = s_reg.f;
	assign rise  = s_reg.r;

	always_comb begin
		s_next      = s_reg;
		s_next.prev = fault_in;
		s_next.r    = |(fault_in & ~s_reg.prev & ~s_reg.f);
		for (int i = 0; i < width; i++) begin
			if (clear)
				s_next.f[i] = fault_in[i];
			if (fault_in[i])
				s_next.f[i] = 1'b1;
		end
		if (clear_extra && !set_extra)
			s_next.f[msg_pkg::restart_bit] = fault_in[msg_pkg::restart_bit];
		if (set_extra) begin
			s_next.f[msg_pkg::restart_bit] = 1'b1;
			s_next.r                       = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			s_reg <= '0;
		else if (clk_en)
			s_reg <= s_next;
	end

	a_flag_keeps_fault: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && fault_in[0] |=> flags[0]) else $error("active fault not held");
endmodule : fault_flags

// ---- rtl/motor_driver_message_handler.sv ----
// Purpose: command interpreter and response generator for the single-wire port
// Assumes: byte framing done outside; bytes arrive as one-cycle strobes
// Notes: replies and unsolicited status leave through an 8-word fifo
`timescale 1ns/1ps
module motor_driver_message_handler #(
	parameter int timeout_cycles = msg_pkg::timeout_cycles,
	parameter int depth          = msg_pkg::fifo_depth
) (
	// clock, reset, enable
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// received bytes from the port layer
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_busy,
	// bytes to transmit
	output logic            tx_valid,
	output logic      [7:0] tx_data,
	input  wire logic       tx_ready,
	input  wire logic       tx_busy,
	// device state
	input  wire logic       chip_enable,
	input  wire logic       sleep_active,
	input  wire logic       restart_event,
	input  wire logic [7:0] fault_zero_in,
	input  wire logic [7:0] fault_one_in,
	// configuration outputs
	output logic            pullup_disconnect,
	output logic            sleep_select,
	output logic            neutral_sim_en,
	output logic            uvlo_disable,
	output logic            short_detect_disable,
	output logic      [1:0] oc_threshold,
	output logic      [7:0] current_ref,
	output logic      [7:0] driver_timing,
	// flag views
	output logic      [7:0] fault_flags_zero,
	output logic      [7:0] fault_flags_one
);
	localparam int tw = $clog2(timeout_cycles + 1);
	typedef struct packed {
		msg_pkg::hstate_t st;
		logic [7:0]       cmd;
		logic [7:0]       dat;
		logic             ack;
		logic             has_data;
		logic [7:0]       rdata;
		logic [tw-1:0]    tmr;
		logic [7:0]       driver_config_zero;
		logic [7:0]       cfg1;
		logic [7:0]       cfg2;
		logic             pend0;
		logic             pend1;
		logic             uns_sel;
		logic             uns_second;
		logic             ce_prev;
		logic             clr0;
		logic             clr1;
		logic             clr_restart;
		logic             toggle_clr;
	} hstate_all_t;
	hstate_all_t s_reg;
	hstate_all_t s_next;
	byte_if #(.width(msg_pkg::byte_w)) push ();
	byte_if #(.width(msg_pkg::byte_w)) pull ();
	logic       rise0;
	logic       rise1;
	logic       needs_data;
	logic       line_quiet;

	byte_fifo #(.width(msg_pkg::byte_w), .depth(depth)) u_fifo (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.wr      (push.sink),
		.rd      (pull.source)
	);

	fault_flags #(.width(8)) u_flags0 (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.fault_in    (fault_zero_in),
		.set_extra   (1'b0),
		.clear       (s_reg.clr0 || s_reg.toggle_clr),
		.clear_extra (1'b0),
		.flags       (fault_flags_zero),
		.rise        (rise0)
	);

	fault_flags #(.width(8)) u_flags1 (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.fault_in    (fault_one_in),
		.set_extra   (restart_event),
		.clear       (s_reg.clr1 || s_reg.toggle_clr),
		.clear_extra (s_reg.clr_restart),
		.flags       (fault_flags_one),
		.rise        (rise1)
	);

	assign tx_valid  = pull.valid;
	assign tx_data   = pull.data;
	assign pull.ready = tx_ready;
	assign line_quiet = !rx_busy && !tx_busy && !pull.valid && s_reg.st == msg_pkg::st_idle;

	// config zero fields; sleep select forces disconnect
	assign pullup_disconnect    = !s_reg.driver_config_zero[msg_pkg::cfg0_pu_bit]
	                              || s_reg.driver_config_zero[msg_pkg::cfg0_sleep_bit];
	assign sleep_select         = s_reg.driver_config_zero[msg_pkg::cfg0_sleep_bit];
	assign neutral_sim_en       = s_reg.driver_config_zero[msg_pkg::cfg0_neut_bit];
	assign uvlo_disable         = s_reg.driver_config_zero[msg_pkg::cfg0_uvlo_bit];
	assign short_detect_disable = s_reg.driver_config_zero[msg_pkg::cfg0_short_bit];
	assign oc_threshold         = s_reg.driver_config_zero[1:0];
	assign current_ref          = s_reg.cfg1;
	assign driver_timing        = s_reg.cfg2;

	always_comb begin
		needs_data = (rx_data == msg_pkg::cmd_set_cfg0) || (rx_data == msg_pkg::cmd_set_cfg1)
		             || (rx_data == msg_pkg::cmd_set_cfg2);
	end

	always_comb begin
		s_next             = s_reg;
		s_next.clr0        = 1'b0;
		s_next.clr1        = 1'b0;
		s_next.clr_restart = 1'b0;
		s_next.ce_prev     = chip_enable;
		s_next.toggle_clr  = chip_enable && !s_reg.ce_prev;
		push.valid         = 1'b0;
		push.data          = 8'h00;
		if (rise0)
			s_next.pend0 = 1'b1;
		if (rise1)
			s_next.pend1 = 1'b1;
		case (s_reg.st)
			msg_pkg::st_idle: begin
				if (rx_valid && !chip_enable) begin
					s_next.cmd = rx_data;
					s_next.tmr = '0;
					if (needs_data)
						s_next.st = msg_pkg::st_wait_data;
					else
						s_next.st = msg_pkg::st_cmd;
				end else if (line_quiet && !chip_enable && !s_reg.uns_second && (s_reg.pend0 || s_reg.pend1)) begin
					// unsolicited status: command code then flag byte
					s_next.uns_sel = !s_reg.pend0;
					push.valid     = 1'b1;
					push.data      = s_reg.pend0 ? msg_pkg::cmd_status0 : msg_pkg::cmd_status1;
					if (push.ready)
						s_next.uns_second = 1'b1;
				end else if (s_reg.uns_second) begin
					push.valid = 1'b1;
					push.data  = s_reg.uns_sel ? fault_flags_one : fault_flags_zero;
					if (push.ready) begin
						s_next.uns_second = 1'b0;
						if (s_reg.uns_sel)
							s_next.pend1 = rise1;
						else
							s_next.pend0 = rise0;
					end
				end
			end
			msg_pkg::st_wait_data: begin
				s_next.tmr = s_reg.tmr + 1'b1;
				if (rx_valid) begin
					s_next.dat = rx_data;
					s_next.st  = msg_pkg::st_cmd;
				end else if (s_reg.tmr >= tw'(timeout_cycles - 1)) begin
					s_next.ack      = 1'b0;
					s_next.has_data = 1'b0;
					s_next.st       = msg_pkg::st_reply;
				end
			end
			msg_pkg::st_cmd: begin
				s_next.ack      = 1'b1;
				s_next.has_data = 1'b0;
				s_next.rdata    = 8'h00;
				s_next.st       = msg_pkg::st_reply;
				if (s_reg.cmd[6:5] != 2'b00 || !s_reg.cmd[7])
					s_next.ack = 1'b0;
				else case (s_reg.cmd)
					msg_pkg::cmd_set_cfg0: begin
						if (s_reg.dat[msg_pkg::cfg0_rsvd_bit])
							s_next.ack = 1'b0;
						else
							s_next.driver_config_zero = s_reg.dat;
					end
					msg_pkg::cmd_set_cfg1: s_next.cfg1 = s_reg.dat;
					msg_pkg::cmd_set_cfg2: s_next.cfg2 = s_reg.dat & msg_pkg::rsvd_mask_cfg2;
					msg_pkg::cmd_get_cfg0: begin
						s_next.has_data = 1'b1;
						s_next.rdata    = s_reg.driver_config_zero;
						if (sleep_active)
							s_next.rdata[msg_pkg::cfg0_pu_bit] = 1'b0;
					end
					msg_pkg::cmd_get_cfg1: begin
						s_next.has_data = 1'b1;
						s_next.rdata    = s_reg.cfg1;
					end
					msg_pkg::cmd_get_cfg2: begin
						s_next.has_data = 1'b1;
						s_next.rdata    = s_reg.cfg2;
					end
					msg_pkg::cmd_status0: begin
						s_next.has_data = 1'b1;
						s_next.rdata    = fault_flags_zero;
						s_next.clr0     = 1'b1;
					end
					msg_pkg::cmd_status1: begin
						s_next.has_data    = 1'b1;
						s_next.rdata       = fault_flags_one;
						s_next.clr1        = 1'b1;
						s_next.clr_restart = 1'b1;
					end
					default: s_next.ack = 1'b0;
				endcase
			end
			msg_pkg::st_reply: begin
				push.valid = 1'b1;
				push.data  = {1'b0, s_reg.ack, s_reg.cmd[5:0]};
				if (push.ready)
					s_next.st = s_reg.has_data ? msg_pkg::st_reply_data : msg_pkg::st_idle;
			end
			msg_pkg::st_reply_data: begin
				push.valid = 1'b1;
				push.data  = s_reg.rdata;
				if (push.ready)
					s_next.st = msg_pkg::st_idle;
			end
			default: s_next.st = msg_pkg::st_idle;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg                    <= '0;
			s_reg.st                 <= msg_pkg::st_idle;
			s_reg.driver_config_zero <= msg_pkg::cfg0_reset;
			s_reg.cfg1               <= msg_pkg::cfg1_reset;
			s_reg.cfg2               <= msg_pkg::cfg2_reset;
			// no false enable edge right after reset, whatever the pin level
			s_reg.ce_prev            <= 1'b1;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// protocol checks
	a_reply_bit_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		s_reg.st == msg_pkg::st_reply |-> push.data[msg_pkg::resp_bit] == 1'b0)
		else $error("response bit7 set");
	a_reply_echo: assert property (@(posedge mclk) disable iff (sys_rst)
		s_reg.st == msg_pkg::st_reply |-> push.data[4:0] == s_reg.cmd[4:0])
		else $error("echo mismatch");
	a_timeout_nack: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_wait_data && !rx_valid && s_reg.tmr == tw'(timeout_cycles - 1)
		|=> s_reg.st == msg_pkg::st_reply && !s_reg.ack) else $error("timeout not nacked");
	a_cfg0_write: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_set_cfg0 && !s_reg.dat[7]
		|=> s_reg.driver_config_zero == $past(s_reg.dat)) else $error("cfg0 not written");
	a_cfg0_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_set_cfg0 && s_reg.dat[7]
		|=> !s_reg.ack && $stable(s_reg.driver_config_zero)) else $error("reserved cfg0 write taken");
	a_cfg0_read: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_get_cfg0
		|=> s_reg.ack && s_reg.rdata[5:0] == s_reg.driver_config_zero[5:0]) else $error("cfg0 read wrong");
	a_cfg1_write: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_set_cfg1
		|=> !s_reg.has_data && s_reg.cfg1 == $past(s_reg.dat)) else $error("cfg1 not written");
	a_cfg1_read: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_get_cfg1
		|=> s_reg.has_data && s_reg.rdata == s_reg.cfg1) else $error("cfg1 read wrong");
	a_cfg2_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
		driver_timing[7:5] == 3'b000)
		else $error("cfg2 reserved bits set");
	a_unknown_nack: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd[4:0] == 5'h1f
		|=> !s_reg.ack) else $error("bad cmd acked");
	a_bad_format_nack: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && (s_reg.cmd[6:5] != 2'b00 || !s_reg.cmd[7])
		|=> !s_reg.ack) else $error("malformed cmd acked");
	a_sleep_disconnect: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_set_cfg0 && s_reg.dat[7:5] == 3'b011
		|=> sleep_select && pullup_disconnect) else $error("sleep without disconnect");
	a_enable_high_ignore: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_idle && rx_valid && chip_enable |=> s_reg.st == msg_pkg::st_idle)
		else $error("command taken with enable high");
	a_restart_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_status1
		##1 clk_en && !restart_event && !fault_one_in[0] |=> !fault_flags_one[0]) else $error("restart flag kept");
	a_status0_data: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_status0
		|=> s_reg.has_data && s_reg.rdata == $past(fault_flags_zero)) else $error("status0 data wrong");
	a_status1_data: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_status1
		|=> s_reg.has_data && s_reg.rdata == $past(fault_flags_one)) else $error("status1 data wrong");
	a_fault_report: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && rise0
		|=> s_reg.pend0) else $error("new fault not queued");
	a_enable_toggle_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && chip_enable && !s_reg.ce_prev ##1 clk_en && fault_zero_in == 8'h00
		|=> fault_flags_zero == 8'h00) else $error("enable toggle did not clear");
	a_unsol_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		s_reg.st == msg_pkg::st_idle && push.valid && !s_reg.uns_second
		|-> !rx_busy && !tx_busy && !chip_enable) else $error("unsolicited on busy line");
	a_data_follows: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && s_reg.st == msg_pkg::st_reply && s_reg.has_data && push.ready
		|=> s_reg.st == msg_pkg::st_reply_data) else $error("data byte missing");
	c_write_cfg0: cover property (@(posedge mclk) s_reg.st == msg_pkg::st_cmd && s_reg.cmd == msg_pkg::cmd_set_cfg0);
	c_read_status1: cover property (@(posedge mclk) s_reg.st == msg_pkg::st_reply_data && s_reg.cmd == msg_pkg::cmd_status1);
	c_timeout: cover property (@(posedge mclk) s_reg.st == msg_pkg::st_wait_data ##1 s_reg.st == msg_pkg::st_reply);
	c_unsolicited: cover property (@(posedge mclk) s_reg.uns_second && push.ready);
	c_enable_clear: cover property (@(posedge mclk) s_reg.toggle_clr);
endmodule : motor_driver_message_handler

// ---- verification/host_model.sv ----
// Purpose: host side of the device byte stream
// Assumes: byte view of the single wire, framing shortened to ten cycles
// Notes: slow holds off ready after each byte to stall the device
`timescale 1ns/1ps
module host_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// device bytes
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            tx_busy,
	// control and view
	input  wire logic       slow,
	output logic            got_valid,
	output logic      [7:0] got_data
);
	logic [3:0] shift_reg;
	logic [3:0] stall_reg;
	assign tx_busy  = shift_reg != 4'h0;
	assign tx_ready = !tx_busy && stall_reg == 4'h0;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_reg <= 4'h0;
			stall_reg <= 4'h0;
			got_valid <= 1'b0;
			got_data  <= 8'h00;
		end else begin
			got_valid <= 1'b0;
			if (shift_reg != 4'h0) begin
				shift_reg <= shift_reg - 4'h1;
			end else if (tx_valid && tx_ready) begin
				// takes the byte and never answers it
				got_valid <= 1'b1;
				got_data  <= tx_data;
				shift_reg <= 4'ha;
				stall_reg <= slow ? 4'h7 : 4'h0;
			end else if (stall_reg != 4'h0) begin
				stall_reg <= stall_reg - 4'h1;
			end
		end
	end
endmodule : host_model

// ---- verification/motor_driver_message_handler_test.sv ----
// Purpose: self-checking bench for the message handler
// Assumes: host model takes device bytes; bench sends host bytes
// Notes: timeout shortened to 50 cycles
`timescale 1ns/1ps
module motor_driver_message_handler_test;
	logic       mclk, sys_rst, clk_en, rx_valid, rx_busy, tx_valid, tx_ready, tx_busy;
	logic       chip_enable, sleep_active, restart_event, slow, got_valid;
	logic [7:0] rx_data, tx_data, fault_zero_in, fault_one_in, got_data;
	logic       pullup_disconnect, sleep_select, neutral_sim_en, uvlo_disable, short_detect_disable;
	logic [1:0] oc_threshold;
	logic [7:0] current_ref, driver_timing, fault_flags_zero, fault_flags_one;
	logic [7:0] q[$];
	int         errors, samples_checked, i;
	motor_driver_message_handler #(.timeout_cycles(50), .depth(msg_pkg::fifo_depth)) DUT (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_busy(rx_busy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_busy(tx_busy),
		.chip_enable(chip_enable), .sleep_active(sleep_active), .restart_event(restart_event),
		.fault_zero_in(fault_zero_in), .fault_one_in(fault_one_in), .pullup_disconnect(pullup_disconnect),
		.sleep_select(sleep_select), .neutral_sim_en(neutral_sim_en), .uvlo_disable(uvlo_disable),
		.short_detect_disable(short_detect_disable), .oc_threshold(oc_threshold), .current_ref(current_ref),
		.driver_timing(driver_timing), .fault_flags_zero(fault_flags_zero), .fault_flags_one(fault_flags_one));
	host_model host (.mclk(mclk), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .tx_busy(tx_busy), .slow(slow), .got_valid(got_valid), .got_data(got_data));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (got_valid === 1'b1) q.push_back(got_data);
	end
	// config outputs packed in register bit order
	function automatic logic [7:0] cfg_view();
		return {1'b0, pullup_disconnect, sleep_select, neutral_sim_en, uvlo_disable, short_detect_disable,
			oc_threshold};
	endfunction : cfg_view
	task automatic check_rx(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: host got %h, expected %h", $time, got, exp);
		end
	endtask : check_rx
	task automatic check_port(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: port shows %h, expected %h", $time, got, exp);
		end
	endtask : check_port
	task automatic send_byte(input logic [7:0] b);
		int n;
		n = 0;
		// half duplex: wait until the device has finished shifting
		while (tx_busy !== 1'b0 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		rx_busy = 1'b1;
		@(negedge mclk);
		rx_valid = 1'b1;
		rx_data  = b;
		rx_busy  = 1'b0;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_data  = ~b;
	endtask : send_byte
	task automatic expect_byte(input logic [7:0] exp);
		int n;
		n = 0;
		while (q.size() == 0 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		if (q.size() == 0) begin
			errors++;
			$display("wrong value at %0t: no byte, expected %h", $time, exp);
		end else begin
			check_rx(q.pop_front(), exp);
		end
	endtask : expect_byte
	task automatic expect_quiet(input int cycles);
		repeat (cycles) @(negedge mclk);
		check_port(8'(q.size()), 8'h00);
	endtask : expect_quiet
	task automatic write_cmd(input logic [7:0] c, input logic [7:0] d, input logic [7:0] r);
		send_byte(c);
		send_byte(d);
		expect_byte(r);
	endtask : write_cmd
	task automatic read_cmd(input logic [7:0] c, input logic [7:0] r, input logic [7:0] d);
		send_byte(c);
		expect_byte(r);
		expect_byte(d);
	endtask : read_cmd
	task automatic give_verdict();
		$display("errors %0d, samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (30000) @(posedge mclk);
		errors++;
		give_verdict();
	end
	initial begin
		{sys_rst, clk_en, rx_valid, rx_busy, chip_enable, sleep_active, restart_event, slow} = 8'h c0;
		{rx_data, fault_zero_in, fault_one_in} = 24'h000000;
		errors = 0;
		samples_checked = 0;
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		check_port(cfg_view(), 8'h40);
		check_port(current_ref, 8'h40);
		check_port(driver_timing, 8'h00);
		restart_event = 1'b1;
		@(negedge mclk);
		restart_event = 1'b0;
		expect_byte(8'h86);
		expect_byte(8'h01);
		read_cmd(8'h86, 8'h46, 8'h01);
		read_cmd(8'h86, 8'h46, 8'h00);
		for (i = 0; i < 4; i++) begin
			write_cmd(8'h81, 8'h1c | 8'(i), 8'h41);
			check_port(cfg_view(), 8'h5c | 8'(i));
			read_cmd(8'h82, 8'h42, 8'h1c | 8'(i));
		end
		write_cmd(8'h81, 8'h60, 8'h41);
		check_port(cfg_view(), 8'h60);
		write_cmd(8'h81, 8'h40, 8'h41);
		check_port(cfg_view(), 8'h00);
		sleep_active = 1'b1;
		read_cmd(8'h82, 8'h42, 8'h00);
		sleep_active = 1'b0;
		write_cmd(8'h81, 8'h80, 8'h01);
		read_cmd(8'h82, 8'h42, 8'h40);
		slow = 1'b1;
		write_cmd(8'h83, 8'ha5, 8'h43);
		check_port(current_ref, 8'ha5);
		read_cmd(8'h84, 8'h44, 8'ha5);
		slow = 1'b0;
		write_cmd(8'h87, 8'hff, 8'h47);
		check_port(driver_timing, 8'h1f);
		read_cmd(8'h88, 8'h48, 8'h1f);
		send_byte(8'h89);
		expect_byte(8'h09);
		send_byte(8'ha1);
		expect_byte(8'h21);
		send_byte(8'h05);
		expect_byte(8'h05);
		send_byte(8'h9f);
		expect_byte(8'h1f);
		send_byte(8'h83);
		expect_quiet(40);
		expect_byte(8'h03);
		// clock enable low freezes the timeout counter
		send_byte(8'h87);
		clk_en = 1'b0;
		expect_quiet(60);
		clk_en = 1'b1;
		expect_quiet(20);
		expect_byte(8'h07);
		chip_enable = 1'b1;
		send_byte(8'h82);
		expect_quiet(30);
		chip_enable = 1'b0;
		fault_zero_in = 8'h08;
		expect_byte(8'h85);
		expect_byte(8'h08);
		read_cmd(8'h85, 8'h45, 8'h08);
		check_port(fault_flags_zero, 8'h08);
		fault_zero_in = 8'h00;
		expect_quiet(30);
		read_cmd(8'h85, 8'h45, 8'h08);
		check_port(fault_flags_zero, 8'h00);
		fault_one_in = 8'h04;
		expect_byte(8'h86);
		expect_byte(8'h04);
		fault_one_in = 8'h00;
		chip_enable = 1'b1;
		@(negedge mclk);
		chip_enable = 1'b0;
		@(negedge mclk);
		check_port(fault_flags_one, 8'h00);
		give_verdict();
	end
endmodule : motor_driver_message_handler_test
